// [core/pic_pkg.sv]
// constants and types shared by the prioritized interrupt controller
package pic_pkg;

    localparam int NUM_SRC = 16;
    localparam int SRC_W   = 4;
    localparam int NUM_LVL = 3;

    // natural priority number equals the source index
    localparam int SRC_PF  = 0;
    localparam int SRC_EX0 = 1;
    localparam int SRC_SP1 = 2;
    localparam int SRC_ADC = 3;
    localparam int SRC_TF0 = 4;
    localparam int SRC_EC0 = 5;
    localparam int SRC_CM0 = 6;
    localparam int SRC_EX1 = 7;
    localparam int SRC_EC1 = 8;
    localparam int SRC_CM1 = 9;
    localparam int SRC_TF1 = 10;
    localparam int SRC_EC2 = 11;
    localparam int SRC_CM2 = 12;
    localparam int SRC_SP0 = 13;
    localparam int SRC_EC3 = 14;
    localparam int SRC_TF2 = 15;

    // global enable position in the enable register
    localparam int GIE_BIT = 7;

    // vector address per source
    localparam logic [7:0] PIC_VEC [0:NUM_SRC-1] = '{
        8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b,
        8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b
    };

    // enable/priority bit of each source within {ext_reg, base_reg}
    localparam logic [3:0] PIC_CTL_BIT [0:NUM_SRC-1] = '{
        4'h0, 4'h0, 4'h5, 4'h6, 4'h1, 4'h8, 4'hc, 4'h2,
        4'h9, 4'hd, 4'h3, 4'ha, 4'he, 4'h4, 4'hb, 4'hf
    };

    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_HIGH = 2'b01,
        LVL_TOP  = 2'b10
    } pic_level_t;

    typedef struct packed {
        logic                pf_flag;
        logic [NUM_LVL-1:0]  srv;
        logic                req;
        pic_level_t          level;
        logic [7:0]          vec;
        logic [NUM_SRC-1:0]  pend;
    } pic_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } pic_sync_t;

endpackage

// [core/pic_sync2.sv]
// two-stage synchroniser for an asynchronous level
`timescale 1ns/10ps
`default_nettype none
module pic_sync2
    import pic_pkg::*;
(
    // clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic ce,
    // level in and out
    input  wire logic d,
    output logic      q
);

    pic_sync_t s_r;
    pic_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            s_nxt.s1 = d;
            s_nxt.s2 = s_r.s1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;

endmodule
`default_nettype wire

// [core/pic_pick.sv]
// lowest-index picker over the request vector
`timescale 1ns/10ps
`default_nettype none
module pic_pick
    import pic_pkg::*;
(
    // requests
    input  wire logic [NUM_SRC-1:0] req,
    // winner
    output logic                    valid,
    output logic [SRC_W-1:0]        idx
);

    logic [NUM_SRC:0]   lower;
    logic [SRC_W-1:0]   acc [0:NUM_SRC];

    assign lower[0] = 1'b0;
    assign acc[0]   = '0;

    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_bit
            logic win;
            assign win        = req[i] & ~lower[i];
            assign lower[i+1] = lower[i] | req[i];
            assign acc[i+1]   = acc[i] | (win ? SRC_W'(i) : '0);
        end
    endgenerate

    assign valid = lower[NUM_SRC];
    assign idx   = acc[NUM_SRC];

endmodule
`default_nettype wire

// [core/pic_top.sv]
// prioritized interrupt controller: gating, three levels, vectoring
// Functional notes
// - enabled power-fail warning with supply below threshold vectors to 0033h.
// - power-fail interrupt vectors only while its enable bit is one.
// - power-fail condition sets flag bit 4 regardless of enable; only software clears.
// - power-fail bypasses global enable; others need own and global enable.
// - global enable bit 7 cleared blocks every source except power-fail.
// - three levels; top only power-fail; others high when priority bit set.
// - within one level the lowest natural priority number wins.
// - sixteen sources, each with own vector and natural priority 0 to 15.
// - serial port 1 receive or transmit requests vector 0Bh, priority 2.
// - serial port 0 receive or transmit requests vector 6Bh, priority 13.
// - external 2 / capture 0 share flag, enable, priority; 23h, priority 5.
// - external 3 / capture 1 share flag, enable, priority; 43h, priority 8.
// - external 4 / capture 2 share flag, enable, priority; 5Bh, priority 11.
// - external 5 / capture 3 share flag, enable, priority; 73h, priority 14.
// - external 0 at 03h, converter at 13h, timer 0 at 1Bh.
// - compare matches 0,1,2 at 2Bh, 4Bh, 63h; priorities 6, 9, 12.
// - external 1 at 3Bh, timer 1 at 53h, timer 2 either flag at 7Bh.
// - clear priority bits mean low priority; natural order alone decides.
`timescale 1ns/10ps
`default_nettype none
module pic_top
    import pic_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // supply monitor comparator, asynchronous
    input  wire logic        below_power_warning_threshold,
    // watchdog control bits
    input  wire logic        power_fail_irq_enable,
    input  wire logic        power_fail_flag_clr,
    output logic             power_fail_warning_irq,
    // enable and priority registers
    input  wire logic [7:0]  irq_enable_reg,
    input  wire logic [7:0]  ext_irq_enable_reg,
    input  wire logic [7:0]  irq_priority_reg,
    input  wire logic [7:0]  ext_irq_priority_reg,
    // peripheral flags
    input  wire logic        external_irq_0,
    input  wire logic        external_irq_1,
    input  wire logic        external_irq_2_capture_0,
    input  wire logic        external_irq_3_capture_1,
    input  wire logic        external_irq_4_capture_2,
    input  wire logic        external_irq_5_capture_3,
    input  wire logic        serial0_receive_flag,
    input  wire logic        serial0_transmit_flag,
    input  wire logic        serial1_receive_flag,
    input  wire logic        serial1_transmit_flag,
    input  wire logic        adc_conversion_done,
    input  wire logic        timer0_overflow_flag,
    input  wire logic        timer1_overflow_flag,
    input  wire logic        timer2_overflow_flag,
    input  wire logic        timer2_second_overflow_flag,
    input  wire logic        compare0_match_flag,
    input  wire logic        compare1_match_flag,
    input  wire logic        compare2_match_flag,
    // processor core handshake
    input  wire logic        irq_ack,
    input  wire logic        irq_return,
    output logic             irq_req,
    output logic [7:0]       irq_vector,
    output logic [1:0]       irq_level,
    // status
    output logic [2:0]       irq_in_service,
    output logic [15:0]      irq_pending
);

    pic_state_t s_r;
    pic_state_t s_nxt;

    logic               pf_cond;
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] ctl_en;
    logic [NUM_SRC-1:0] ctl_pri;
    logic [NUM_SRC-1:0] req_all;
    logic [NUM_SRC-1:0] req_hi;
    logic [NUM_SRC-1:0] req_lo;
    logic               hi_valid;
    logic               lo_valid;
    logic [SRC_W-1:0]   hi_idx;
    logic [SRC_W-1:0]   lo_idx;
    logic               gie;
    logic [NUM_SRC-1:0] en_cat;
    logic [NUM_SRC-1:0] pri_cat;
    logic               lo_only;

    // comparator is analog-side, so synchronise before use
    pic_sync2 u_pf_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .d       (below_power_warning_threshold),
        .q       (pf_cond)
    );

    // source flags by natural priority
    assign src_flag[SRC_PF]  = s_r.pf_flag;
    assign src_flag[SRC_EX0] = external_irq_0;
    assign src_flag[SRC_SP1] = serial1_receive_flag | serial1_transmit_flag;
    assign src_flag[SRC_ADC] = adc_conversion_done;
    assign src_flag[SRC_TF0] = timer0_overflow_flag;
    assign src_flag[SRC_EC0] = external_irq_2_capture_0;
    assign src_flag[SRC_CM0] = compare0_match_flag;
    assign src_flag[SRC_EX1] = external_irq_1;
    assign src_flag[SRC_EC1] = external_irq_3_capture_1;
    assign src_flag[SRC_CM1] = compare1_match_flag;
    assign src_flag[SRC_TF1] = timer1_overflow_flag;
    assign src_flag[SRC_EC2] = external_irq_4_capture_2;
    assign src_flag[SRC_CM2] = compare2_match_flag;
    assign src_flag[SRC_SP0] = serial0_receive_flag | serial0_transmit_flag;
    assign src_flag[SRC_EC3] = external_irq_5_capture_3;
    assign src_flag[SRC_TF2] = timer2_overflow_flag | timer2_second_overflow_flag;

    assign gie = irq_enable_reg[GIE_BIT];
    // named so each slice can index its own control bit
    assign en_cat  = {ext_irq_enable_reg, irq_enable_reg};
    assign pri_cat = {ext_irq_priority_reg, irq_priority_reg};

    // per-source gating and level split, one slice each, table-driven except power-fail
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            if (g == SRC_PF) begin : g_pf
                assign ctl_en[g]  = power_fail_irq_enable;
                assign ctl_pri[g] = 1'b0;
                assign req_all[g] = src_flag[g] & ctl_en[g];
            end else begin : g_std
                assign ctl_en[g]  = en_cat[PIC_CTL_BIT[g]];
                assign ctl_pri[g] = pri_cat[PIC_CTL_BIT[g]];
                assign req_all[g] = src_flag[g] & ctl_en[g] & gie;
            end
            // cleared priority bit lands in low level
            assign req_hi[g] = (g != SRC_PF) & req_all[g] & ctl_pri[g];
            assign req_lo[g] = (g != SRC_PF) & req_all[g] & ~ctl_pri[g];
        end
    endgenerate

    pic_pick u_pick_hi (
        .req   (req_hi),
        .valid (hi_valid),
        .idx   (hi_idx)
    );

    pic_pick u_pick_lo (
        .req   (req_lo),
        .valid (lo_valid),
        .idx   (lo_idx)
    );

    // only a low request can win at the next edge
    assign lo_only = ce & (s_r.srv == '0) & ~irq_ack & ~req_all[SRC_PF]
                   & ~hi_valid & lo_valid;

    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            // set beats software clear in the same cycle
            if (pf_cond) begin
                s_nxt.pf_flag = 1'b1;
            end else if (power_fail_flag_clr) begin
                s_nxt.pf_flag = 1'b0;
            end
            // return retires the highest active level first
            if (irq_return) begin
                if (s_r.srv[LVL_TOP]) begin
                    s_nxt.srv[LVL_TOP] = 1'b0;
                end else if (s_r.srv[LVL_HIGH]) begin
                    s_nxt.srv[LVL_HIGH] = 1'b0;
                end else begin
                    s_nxt.srv[LVL_LOW] = 1'b0;
                end
            end
            if (irq_ack && s_r.req) begin
                s_nxt.srv[s_r.level] = 1'b1;
            end
            s_nxt.pend = req_all;
            // a request must outrank everything in service
            s_nxt.req   = 1'b0;
            s_nxt.level = LVL_LOW;
            s_nxt.vec   = s_r.vec;
            if (req_all[SRC_PF] && !s_nxt.srv[LVL_TOP]) begin
                s_nxt.req   = 1'b1;
                s_nxt.level = LVL_TOP;
                s_nxt.vec   = PIC_VEC[SRC_PF];
            end else if (hi_valid && s_nxt.srv[LVL_TOP:LVL_HIGH] == '0) begin
                s_nxt.req   = 1'b1;
                s_nxt.level = LVL_HIGH;
                s_nxt.vec   = PIC_VEC[hi_idx];
            end else if (lo_valid && s_nxt.srv == '0) begin
                s_nxt.req   = 1'b1;
                s_nxt.level = LVL_LOW;
                s_nxt.vec   = PIC_VEC[lo_idx];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign power_fail_warning_irq = s_r.pf_flag;
    assign irq_req                = s_r.req;
    assign irq_vector             = s_r.vec;
    assign irq_level              = s_r.level;
    assign irq_in_service         = s_r.srv;
    assign irq_pending            = s_r.pend;

    AST_PF_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && pf_cond |=> power_fail_warning_irq)
        else $error("power-fail flag not set by condition");

    AST_PF_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!ce || !power_fail_flag_clr) && power_fail_warning_irq |=> power_fail_warning_irq)
        else $error("power-fail flag dropped without software clear");

    AST_PF_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq_req && irq_level == LVL_TOP |-> irq_vector == 8'h33 &&
        (power_fail_warning_irq || $past(power_fail_warning_irq)))
        else $error("top-level request without power-fail vector");

    AST_PF_ENABLE: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && !power_fail_irq_enable |=> !(irq_req && irq_level == LVL_TOP))
        else $error("power-fail vectored while disabled");

    AST_GLOBAL_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && !irq_enable_reg[GIE_BIT] |=> !irq_req || irq_level == LVL_TOP)
        else $error("maskable request with global enable clear");

    AST_LOW_WAITS: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq_req && irq_level == LVL_LOW |-> irq_in_service == 3'h0)
        else $error("low request while a routine is in service");

    AST_HIGH_WAITS: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq_req && irq_level == LVL_HIGH |-> irq_in_service[2:1] == 2'h0)
        else $error("high request while high or top in service");

    AST_ACK_MARKS: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && irq_ack && irq_req && !irq_return |=> irq_in_service[$past(irq_level)])
        else $error("acknowledge did not mark level in service");

    AST_LOW_ORDER: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_valid |-> req_lo[lo_idx] && (req_lo & ((16'h1 << lo_idx) - 16'h1)) == 16'h0)
        else $error("low picker skipped a lower natural number");

    AST_DEFAULT_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && irq_priority_reg == 8'h0 && ext_irq_priority_reg == 8'h0
        |=> !(irq_req && irq_level == LVL_HIGH))
        else $error("high request with all priority bits clear");

    AST_HIGH_ORDER: assert property (@(posedge sys_clk) disable iff (!rstn)
        hi_valid |-> req_hi[hi_idx] && (req_hi & ((16'h1 << hi_idx) - 16'h1)) == 16'h0)
        else $error("high picker skipped a lower natural number");

    AST_PF_ONLY_TOP: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq_req && irq_vector == 8'h33 |-> irq_level == LVL_TOP)
        else $error("power-fail vector outside top level");

    AST_EX0_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_EX0 |=> irq_req && irq_vector == 8'h03)
        else $error("external 0 wrong vector");

    AST_SP1_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_SP1 |=> irq_req && irq_vector == 8'h0b)
        else $error("serial port 1 wrong vector");

    AST_EC0_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_EC0 |=> irq_req && irq_vector == 8'h23)
        else $error("external 2 / capture 0 wrong vector");

    AST_CM0_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_CM0 |=> irq_req && irq_vector == 8'h2b)
        else $error("compare 0 wrong vector");

    AST_EC1_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_EC1 |=> irq_req && irq_vector == 8'h43)
        else $error("external 3 / capture 1 wrong vector");

    AST_TF1_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_TF1 |=> irq_req && irq_vector == 8'h53)
        else $error("timer 1 wrong vector");

    AST_EC2_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_EC2 |=> irq_req && irq_vector == 8'h5b)
        else $error("external 4 / capture 2 wrong vector");

    AST_CM2_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_CM2 |=> irq_req && irq_vector == 8'h63)
        else $error("compare 2 wrong vector");

    AST_SP0_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_SP0 |=> irq_req && irq_vector == 8'h6b)
        else $error("serial port 0 wrong vector");

    AST_EC3_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_EC3 |=> irq_req && irq_vector == 8'h73)
        else $error("external 5 / capture 3 wrong vector");

    AST_TF2_VECTOR: assert property (@(posedge sys_clk) disable iff (!rstn)
        lo_only && lo_idx == SRC_TF2 |=> irq_req && irq_vector == 8'h7b)
        else $error("timer 2 wrong vector");

endmodule
`default_nettype wire

// [verification/pic_core_model.sv]
// processor core model: takes presented vectors promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // request from the controller, pacing choice
    input  wire logic irq_req,
    input  wire logic slow,
    // acknowledge to the controller
    output logic      irq_ack
);
    logic [1:0] wait_r;

    // ack is held until the edge that samples it, then dropped
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_ack <= 1'b0;
            wait_r  <= 2'h0;
        end else if (irq_ack || !irq_req) begin
            irq_ack <= 1'b0;
            wait_r  <= 2'h0;
        end else if (!slow || wait_r == 2'h3) begin
            irq_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// [verification/pic_top_tb.sv]
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module pic_top_tb;
    localparam int         CB [16] = '{0, 0, 5, 6, 1, 8, 12, 2, 9, 13, 3, 10, 14, 4, 11, 15};
    localparam logic [7:0] VT [16] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
        8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b};
    logic        sys_clk, rstn, slow, pf_below, pf_en, pf_clr, irq_return, gie;
    logic        irq_ack, irq_req, pf_flag;
    logic [15:0] fl, alt, en, pr, ec, pc, pend;
    logic [7:0]  vec;
    logic [1:0]  lvl;
    logic [2:0]  insvc;
    logic [31:0] rnd;
    logic [9:0]  exp_v;
    logic [9:0]  exp_q [$];
    int          ord_q [$];
    int          err_count, n_compared, n_taken, cyc;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // per-source bit to its place in {extended, base} register pair
    function automatic logic [15:0] cmap(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 1; i < 16; i++) r[CB[i]] = v[i];
        return r;
    endfunction

    assign ec = cmap(en);
    assign pc = cmap(pr);

    pic_top pic_top_inst (
        .sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
        .below_power_warning_threshold(pf_below), .power_fail_irq_enable(pf_en),
        .power_fail_flag_clr(pf_clr), .power_fail_warning_irq(pf_flag),
        .irq_enable_reg({gie, ec[6:0]}), .ext_irq_enable_reg(ec[15:8]),
        .irq_priority_reg(pc[7:0]), .ext_irq_priority_reg(pc[15:8]),
        .external_irq_0(fl[1]), .external_irq_1(fl[7]),
        .external_irq_2_capture_0(fl[5]), .external_irq_3_capture_1(fl[8]),
        .external_irq_4_capture_2(fl[11]), .external_irq_5_capture_3(fl[14]),
        .serial0_receive_flag(fl[13] & ~alt[13]), .serial0_transmit_flag(fl[13] & alt[13]),
        .serial1_receive_flag(fl[2] & ~alt[2]), .serial1_transmit_flag(fl[2] & alt[2]),
        .adc_conversion_done(fl[3]), .timer0_overflow_flag(fl[4]),
        .timer1_overflow_flag(fl[10]), .timer2_overflow_flag(fl[15] & ~alt[15]),
        .timer2_second_overflow_flag(fl[15] & alt[15]), .compare0_match_flag(fl[6]),
        .compare1_match_flag(fl[9]), .compare2_match_flag(fl[12]),
        .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
        .irq_vector(vec), .irq_level(lvl), .irq_in_service(insvc), .irq_pending(pend)
    );

    pic_core_model pic_core_model_inst (
        .sys_clk(sys_clk), .rstn(rstn), .irq_req(irq_req), .slow(slow), .irq_ack(irq_ack)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // bounded wait for the core model to take one vector
    task automatic wait_take;
        int t0;
        int k;
        t0 = n_taken;
        k  = 0;
        while (n_taken == t0 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK("vector taken", 1'b1, n_taken != t0)
    endtask

    task automatic ret;
        @(negedge sys_clk);
        irq_return = 1'b1;
        @(negedge sys_clk);
        irq_return = 1'b0;
    endtask

    // each taken vector is matched against the oldest note
    always @(posedge sys_clk) begin
        if (rstn === 1'b1 && irq_ack === 1'b1 && irq_req === 1'b1) begin
            n_taken++;
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error take expected none seen %h", vec);
            end else begin
                exp_v = exp_q.pop_front();
                `CHK("level and vector", exp_v, {lvl, vec})
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("Error timeout expected done seen cycle %0d", cyc);
            final_report();
        end
    end

    initial begin
        {rstn, slow, pf_below, pf_en, pf_clr, irq_return, gie} = '0;
        {fl, alt, en, pr} = '0;
        rnd = 32'ha555;
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        `CHK("in service", 3'h0, insvc)
        // all fifteen at once: high level first, natural order within a level
        for (int p = 0; p < 2; p++) begin
            // global off again, so no vector is taken before its note is queued
            gie = 1'b0;
            slow = p[0];
            rnd = lfsr(rnd);
            alt = rnd[15:0];
            rnd = lfsr(rnd);
            pr = p[0] ? {rnd[15:1], 1'b0} : 16'h0;
            en = 16'hfffe;
            fl = 16'hfffe;
            repeat (5) @(negedge sys_clk);
            `CHK("request global off", 1'b0, irq_req)
            for (int l = 1; l >= 0; l--)
                for (int i = 1; i < 16; i++)
                    if (pr[i] == l) begin
                        exp_q.push_back({l[1:0], VT[i]});
                        ord_q.push_back(i);
                    end
            gie = 1'b1;
            while (ord_q.size() > 0) begin
                wait_take();
                fl[ord_q.pop_front()] = 1'b0;
                ret();
            end
        end
        // nesting: high preempts low, same level waits
        slow = 1'b0;
        pr = 16'h8000;
        en = 16'h8006;
        exp_q.push_back({2'h0, 8'h03});
        fl[1] = 1'b1;
        wait_take();
        fl[1] = 1'b0;
        fl[2] = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK("same level held", 1'b0, irq_req)
        `CHK("pending", 16'h0004, pend)
        exp_q.push_back({2'h1, 8'h7b});
        fl[15] = 1'b1;
        wait_take();
        fl[15] = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("nested service", 3'h3, insvc)
        exp_q.push_back({2'h0, 8'h0b});
        ret();
        ret();
        wait_take();
        fl[2] = 1'b0;
        ret();
        // power-fail: flag apart from enable, bypasses global enable
        en = 16'h0;
        gie = 1'b0;
        pf_below = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK("pf flag set", 1'b1, pf_flag)
        `CHK("pf disabled", 1'b0, irq_req)
        pf_clr = 1'b1;
        @(negedge sys_clk);
        pf_clr = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("pf set beats clear", 1'b1, pf_flag)
        exp_q.push_back({2'h2, 8'h33});
        pf_en = 1'b1;
        wait_take();
        pf_below = 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK("pf flag kept", 1'b1, pf_flag)
        pf_clr = 1'b1;
        @(negedge sys_clk);
        pf_clr = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("pf flag cleared", 1'b0, pf_flag)
        ret();
        repeat (5) @(negedge sys_clk);
        `CHK("notes left", 0, exp_q.size())
        final_report();
    end
endmodule
`default_nettype wire
